//--- rtl/odt_pd_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "odt_pd_regs.svh"

module odt_pd_ctrl #(
  parameter int MAX_WL        = 16,
  parameter int CNT_W         = 8,
  parameter int CMD_DELAY_CYC = `ODT_CMD_DELAY_CYC,
  parameter int EXIT_LOCK_CYC = `ODT_EXIT_LOCK_CYC,
  parameter int REFRESH_CYC   = `ODT_REFRESH_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // pins sampled at the clock edge
  input  wire logic                 cke,
  input  wire logic                 odt,
  // decoded commands and configuration
  input  wire logic                 refreshCmd,
  input  wire logic                 banksIdle,
  input  wire logic                 mr0PdDllFast,
  input  wire odt_pd_pkg::latency_t writeLatency,
  // termination and mode status
  output logic                      rttOn_q,
  output logic                      asyncMode_q,
  output logic                      windowOpen_q,
  output logic                      pdActive_q,
  output logic                      cmdRxEn_q,
  output logic                      odtRxEn_q
);
  import odt_pd_pkg::*;

  localparam int ASYNC_MIN = `ODT_ASYNC_MIN_CYC;
  localparam int ASYNC_MAX = `ODT_ASYNC_MAX_CYC;
  localparam logic [CNT_W-1:0] CMD_CNT  = CNT_W'(CMD_DELAY_CYC);
  localparam logic [CNT_W-1:0] EXIT_CNT = CNT_W'(EXIT_LOCK_CYC);
  localparam logic [CNT_W-1:0] REF_CNT  = CNT_W'(REFRESH_CYC);

  if (MAX_WL < 4 || MAX_WL > 16 || CMD_DELAY_CYC < 1 || EXIT_LOCK_CYC < 1 ||
      REFRESH_CYC < 1 || REFRESH_CYC >= (1 << CNT_W) ||
      EXIT_LOCK_CYC >= (1 << CNT_W) || CMD_DELAY_CYC >= (1 << CNT_W) ||
      ASYNC_MIN > ASYNC_MAX) begin : g_param_chk
    $error("odt_pd_ctrl: parameters out of range");
  end

  pdState_t         state_q, state_d;
  logic [CNT_W-1:0] winCnt_q, winCnt_d;
  logic [CNT_W-1:0] refCnt_q, refCnt_d;
  logic             ckePrev_q, ckePrev_d;
  logic             odtSmp_q, odtSmp_d;
  logic             frozen_q, frozen_d;
  logic             rttOn_d, asyncMode_d, windowOpen_d, pdActive_d;
  logic             cmdRxEn_d;
  logic             ckeFall, ckeRise;
  logic [CNT_W-1:0] cntLeft, entryLoad, refLeft;

  odt_delay_if dly ();

  odt_delay_line #(
    .DEPTH (MAX_WL)
  ) u_sync_delay (
    .clk   (clk),
    .rst_n (rst_n),
    .dl    (dly)
  );

  function automatic logic [CNT_W-1:0] maxCnt(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    maxCnt = (a > b) ? a : b;
  endfunction

  // request rides the clocked line; registered output adds the last cycle
  assign dly.odtIn  = odt;
  assign dly.tapSel = latency_t'(writeLatency -
                      latency_t'(`ODT_SYNC_LAT_SUB + 1));

  assign ckeFall   = ckePrev_q && !cke;
  assign ckeRise   = !ckePrev_q && cke;
  assign cntLeft   = (winCnt_q > 1) ? winCnt_q - 1'b1 : '0;
  // refresh cycles still due after this edge; a refresh now restarts them
  assign refLeft   = refreshCmd ? REF_CNT
                                : ((refCnt_q != '0) ? refCnt_q - 1'b1 : '0);
  // entry window lasts to the latest of command delay, refresh end and the window still running
  assign entryLoad = maxCnt(maxCnt(CMD_CNT, refLeft), cntLeft);

  // power-down state and window counter
  always_comb begin
    state_d   = state_q;
    winCnt_d  = cntLeft;
    ckePrev_d = cke;
    odtSmp_d  = odt;
    frozen_d  = frozen_q;
    refCnt_d  = refLeft;
    case (state_q)
      ST_ACTIVE: begin
        if (ckeFall) begin
          state_d  = ST_ENTRY;
          winCnt_d = entryLoad;
          // loop freezes only in precharge power-down with A12 low
          frozen_d = !mr0PdDllFast && banksIdle;
        end
      end
      ST_ENTRY: begin
        if (ckeRise) begin
          state_d  = ST_EXIT;
          winCnt_d = maxCnt(EXIT_CNT, cntLeft);
        end else if (winCnt_q <= 1) begin
          state_d = ST_PD;
        end
      end
      ST_PD: begin
        if (ckeRise) begin
          state_d  = ST_EXIT;
          winCnt_d = EXIT_CNT;
        end
      end
      ST_EXIT: begin
        if (ckeFall) begin
          state_d  = ST_ENTRY;
          winCnt_d = entryLoad;
          frozen_d = !mr0PdDllFast && banksIdle;
        end else if (winCnt_q <= 1) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  // mode outputs derived from the next state so each leaves a flop; termination follows the current mode
  always_comb begin
    pdActive_d   = (state_d == ST_ENTRY) || (state_d == ST_PD);
    windowOpen_d = (state_d == ST_ENTRY) || (state_d == ST_EXIT);
    // async only while cke is low and the loop is frozen
    asyncMode_d  = pdActive_d && frozen_d;
    cmdRxEn_d    = !pdActive_d;
    // async uses the request sampled one edge back: no additive latency,
    // and the change lands one period after sampling, never at the edge
    rttOn_d      = asyncMode_q ? odtSmp_q : dly.delayed;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_ACTIVE;
      winCnt_q     <= '0;
      refCnt_q     <= '0;
      ckePrev_q    <= 1'b0;
      odtSmp_q     <= 1'b0;
      frozen_q     <= 1'b0;
      rttOn_q      <= 1'b0;
      asyncMode_q  <= 1'b0;
      windowOpen_q <= 1'b0;
      pdActive_q   <= 1'b0;
      cmdRxEn_q    <= 1'b0;
      odtRxEn_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      winCnt_q     <= winCnt_d;
      refCnt_q     <= refCnt_d;
      ckePrev_q    <= ckePrev_d;
      odtSmp_q     <= odtSmp_d;
      frozen_q     <= frozen_d;
      rttOn_q      <= rttOn_d;
      asyncMode_q  <= asyncMode_d;
      windowOpen_q <= windowOpen_d;
      pdActive_q   <= pdActive_d;
      cmdRxEn_q    <= cmdRxEn_d;
      // the termination receiver is off only in reset, on at every edge after it
      odtRxEn_q    <= 1'b1;
    end
  end

  property p_async_on;
    @(posedge clk) disable iff (!rst_n)
    (asyncMode_q && odt) ##1 asyncMode_q |-> ##[ASYNC_MIN:ASYNC_MAX] rttOn_q;
  endproperty
  a_async_on: assert property (p_async_on)
    else $error("async termination did not turn on in time");

  property p_async_off;
    @(posedge clk) disable iff (!rst_n)
    (asyncMode_q && !odt) ##1 asyncMode_q |-> ##[ASYNC_MIN:ASYNC_MAX] !rttOn_q;
  endproperty
  a_async_off: assert property (p_async_off)
    else $error("async termination did not turn off in time");

  property p_rx_alive;
    @(posedge clk) disable iff (!rst_n)
    pdActive_q |-> odtRxEn_q && !cmdRxEn_q;
  endproperty
  a_rx_alive: assert property (p_rx_alive)
    else $error("termination receiver off in power-down");

  property p_frozen_async;
    @(posedge clk) disable iff (!rst_n)
    (ckeFall && !mr0PdDllFast && banksIdle) |=> asyncMode_q;
  endproperty
  a_frozen_async: assert property (p_frozen_async)
    else $error("frozen power-down entry not in async mode");

  property p_sync_outside;
    @(posedge clk) disable iff (!rst_n)
    ((state_q == ST_ACTIVE || state_q == ST_EXIT) &&
     (!ckeFall || mr0PdDllFast || !banksIdle)) |=> !asyncMode_q;
  endproperty
  a_sync_outside: assert property (p_sync_outside)
    else $error("async mode outside frozen power-down");

  property p_entry_win;
    @(posedge clk) disable iff (!rst_n)
    (ckeFall && refCnt_q <= CMD_CNT && !refreshCmd && state_q == ST_ACTIVE &&
     CMD_DELAY_CYC == 1) |=> windowOpen_q ##1 (!windowOpen_q || $past(cke));
  endproperty
  a_entry_win: assert property (p_entry_win)
    else $error("entry window length wrong");

  property p_refresh_stretch;
    @(posedge clk) disable iff (!rst_n)
    (ckeFall && state_q == ST_ACTIVE && refCnt_q > CMD_CNT && !refreshCmd)
      |=> winCnt_q == $past(refCnt_q) - 1'b1;
  endproperty
  a_refresh_stretch: assert property (p_refresh_stretch)
    else $error("refresh did not stretch entry window");

  property p_exit_win;
    @(posedge clk) disable iff (!rst_n)
    (ckeRise && state_q == ST_PD) |=> windowOpen_q && !pdActive_q &&
      winCnt_q == EXIT_CNT;
  endproperty
  a_exit_win: assert property (p_exit_win)
    else $error("exit window not opened for locked-command delay");

  property p_sync_lat;
    @(posedge clk) disable iff (!rst_n)
    (!asyncMode_q && !$past(asyncMode_q) && writeLatency == 4'h5 &&
     $stable(writeLatency)) |-> ##1 rttOn_q == $past(odt, 4);
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("sync latency not write latency minus two");

  c_entry:   cover property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_ENTRY ##1 state_q == ST_PD);
  c_exit:    cover property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_EXIT ##1 state_q == ST_ACTIVE);
  c_async:   cover property (@(posedge clk) disable iff (!rst_n)
    asyncMode_q && odt ##2 rttOn_q);
  c_overlap: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_ENTRY ##1 state_q == ST_EXIT);

endmodule

`default_nettype wire

//--- rtl/odt_pd_regs.svh
`ifndef ODT_PD_REGS_SVH
`define ODT_PD_REGS_SVH

// clock period and asynchronous termination delays, in picoseconds
`define ODT_CLK_PERIOD_PS   8000
`define ODT_ASYNC_MIN_PS    2000
`define ODT_ASYNC_MAX_PS    8500

// least time rounds up, longest time rounds down, never below one cycle
`define ODT_ASYNC_MIN_CYC \
  ((((`ODT_ASYNC_MIN_PS + `ODT_CLK_PERIOD_PS - 1) / `ODT_CLK_PERIOD_PS) < 1) \
   ? 1 : ((`ODT_ASYNC_MIN_PS + `ODT_CLK_PERIOD_PS - 1) / `ODT_CLK_PERIOD_PS))
`define ODT_ASYNC_MAX_CYC \
  (((`ODT_ASYNC_MAX_PS / `ODT_CLK_PERIOD_PS) < 1) \
   ? 1 : (`ODT_ASYNC_MAX_PS / `ODT_CLK_PERIOD_PS))

// synchronous latency is write latency minus this
`define ODT_SYNC_LAT_SUB    2
// entry/exit look-ahead is write latency minus this
`define ODT_LOOKAHEAD_SUB   1
// termination request must stay high this many cycles
`define ODT_MIN_HIGH_CYC    4
// mode register 0 bit that selects slow (frozen) exit in power-down
`define ODT_MR0_PD_DLL_BIT  12
// plain defaults for window lengths and write latency, in clock cycles
`define ODT_CMD_DELAY_CYC   1
`define ODT_EXIT_LOCK_CYC   10
`define ODT_REFRESH_CYC     64
`define ODT_WL_DEFAULT      5

`endif

//--- rtl/odt_pd_pkg.sv
package odt_pd_pkg;

  // gray-coded along active -> entry -> power-down -> exit -> active
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_ENTRY  = 2'b01,
    ST_PD     = 2'b11,
    ST_EXIT   = 2'b10
  } pdState_t;

  typedef logic [3:0] latency_t;

endpackage

//--- rtl/odt_delay_if.sv
`timescale 1ns/1ns
`default_nettype none

interface odt_delay_if;
  logic                 odtIn;
  odt_pd_pkg::latency_t tapSel;
  logic                 delayed;

  modport src  (output odtIn, output tapSel, input delayed);
  modport line (input odtIn, input tapSel, output delayed);
endinterface

`default_nettype wire

//--- rtl/odt_delay_line.sv
`timescale 1ns/1ns
`default_nettype none

module odt_delay_line #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // request in, tapped request out
  odt_delay_if.line dl
);
  import odt_pd_pkg::*;

  logic [DEPTH-1:0] stage_q;
  logic [DEPTH-1:0] stage_d;

  if (DEPTH < 2 || DEPTH > 16) begin : g_depth_chk
    $error("odt_delay_line: DEPTH must be 2..16");
  end

  // stage i holds the request sampled i+1 edges ago
  always_comb begin
    stage_d = {stage_q[DEPTH-2:0], dl.odtIn};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  // tap beyond the line reads the oldest stage
  assign dl.delayed = (int'(dl.tapSel) < DEPTH) ? stage_q[dl.tapSel]
                                                : stage_q[DEPTH-1];

  property p_stage_shift;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> stage_q[0] == $past(dl.odtIn);
  endproperty
  a_stage_shift: assert property (p_stage_shift)
    else $error("delay line first stage lost the request");

endmodule

`default_nettype wire

//--- bench/ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module ctrl_model (
  // clock
  input  wire logic clk,
  // pins toward the device
  output logic      cke,
  output logic      odt,
  output logic      refreshCmd
);
  int hiCnt = 0;

  initial begin
    cke = 1'b1;
    odt = 1'b0;
    refreshCmd = 1'b0;
  end

  always @(posedge clk) hiCnt <= odt ? hiCnt + 1 : 0;

  // all pins move just after the rising edge, never on it
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // no read or write command exists here, so none can reach power-down
  task automatic setCke(input logic v);
    cke = v;
  endtask

  // the window is tracked by the caller, who schedules odt around it
  task automatic odtOn();
    odt = 1'b1;
  endtask

  // release waits until the request was registered high four times
  task automatic odtOff();
    while (hiCnt < 4) step(1);
    odt = 1'b0;
  endtask

  task automatic refresh();
    refreshCmd = 1'b1;
    step(1);
    refreshCmd = 1'b0;
  endtask
endmodule

`default_nettype wire

//--- bench/odt_power_down_mode_control_test.sv
`timescale 1ns/1ns
`default_nettype none

module odt_power_down_mode_control_test;
  import odt_pd_pkg::*;
  logic     clk;
  logic     rst_n;
  logic     cke;
  logic     odt;
  logic     refreshCmd;
  logic     banksIdle;
  logic     mr0Fast;
  latency_t wl;
  logic     rttOn_q;
  logic     asyncMode_q;
  logic     windowOpen_q;
  logic     pdActive_q;
  logic     cmdRxEn_q;
  logic     odtRxEn_q;
  int       n_mismatch = 0;
  int       cmp_count = 0;
  int       cycles = 0;

  ctrl_model m (.clk(clk), .cke(cke), .odt(odt), .refreshCmd(refreshCmd));

  // short windows keep the run brief
  odt_pd_ctrl #(.CMD_DELAY_CYC(1), .EXIT_LOCK_CYC(3), .REFRESH_CYC(8)) uut (
    .clk(clk), .rst_n(rst_n), .cke(cke), .odt(odt),
    .refreshCmd(refreshCmd), .banksIdle(banksIdle),
    .mr0PdDllFast(mr0Fast), .writeLatency(wl), .rttOn_q(rttOn_q),
    .asyncMode_q(asyncMode_q), .windowOpen_q(windowOpen_q),
    .pdActive_q(pdActive_q), .cmdRxEn_q(cmdRxEn_q), .odtRxEn_q(odtRxEn_q));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic testSync();
    for (int w = 5; w <= 7; w += 2) begin
      wl = latency_t'(w);
      m.step(4);
      m.odtOn();
      m.step(w - 2);
      chk(rttOn_q, 1'b0, "sync on early");
      m.step(1);
      chk(rttOn_q, 1'b1, "sync on late");
      chk(asyncMode_q, 1'b0, "async outside pd");
      m.odtOff();
      m.step(w - 2);
      chk(rttOn_q, 1'b1, "sync off early");
      m.step(1);
      chk(rttOn_q, 1'b0, "sync off late");
    end
    wl = 4'h5;
    m.step(4);
    $display("test sync done");
  endtask

  task automatic testFrozen();
    mr0Fast = 1'b0;
    m.setCke(1'b0);
    m.step(1);
    chk(pdActive_q, 1'b1, "pd entry");
    chk(asyncMode_q, 1'b1, "frozen async");
    chk(windowOpen_q, 1'b1, "entry window");
    chk(cmdRxEn_q, 1'b0, "cmd rx off");
    chk(odtRxEn_q, 1'b1, "odt rx on");
    m.step(1);
    chk(windowOpen_q, 1'b0, "entry window end");
    m.odtOn();
    m.step(1);
    chk(rttOn_q, 1'b0, "async on early");
    m.step(1);
    chk(rttOn_q, 1'b1, "async on, no delay");
    m.odtOff();
    m.step(1);
    chk(rttOn_q, 1'b1, "async off early");
    m.step(1);
    chk(rttOn_q, 1'b0, "async off");
    m.setCke(1'b1);
    m.step(2);
    chk(pdActive_q, 1'b0, "pd exit");
    chk(asyncMode_q, 1'b0, "sync after exit");
    chk(windowOpen_q, 1'b1, "exit window");
    m.step(1);
    chk(windowOpen_q, 1'b1, "exit window held");
    m.step(1);
    chk(windowOpen_q, 1'b0, "exit window end");
    $display("test frozen done");
  endtask

  task automatic testFast();
    mr0Fast = 1'b1;
    m.setCke(1'b0);
    m.step(2);
    chk(pdActive_q, 1'b1, "fast pd entry");
    chk(asyncMode_q, 1'b0, "fast stays sync");
    m.setCke(1'b1);
    m.step(6);
    mr0Fast = 1'b0;
    // open banks: active power-down keeps the loop running
    banksIdle = 1'b0;
    m.setCke(1'b0);
    m.step(1);
    chk(pdActive_q, 1'b1, "active pd entry");
    chk(asyncMode_q, 1'b0, "active pd stays sync");
    m.setCke(1'b1);
    m.step(6);
    banksIdle = 1'b1;
    $display("test fast done");
  endtask

  task automatic testRefresh();
    m.refresh();
    m.setCke(1'b0);
    // refresh one edge before the fall: window closes eight edges after it
    m.step(7);
    chk(windowOpen_q, 1'b1, "refresh stretches window");
    m.step(1);
    chk(windowOpen_q, 1'b0, "refresh window ends");
    m.setCke(1'b1);
    m.step(6);
    $display("test refresh done");
  endtask

  task automatic testShort();
    m.setCke(1'b0);
    m.step(1);
    m.setCke(1'b1);
    for (int i = 0; i < 3; i++) begin
      m.step(1);
      chk(windowOpen_q, 1'b1, "short pd merge");
    end
    m.setCke(1'b0);
    m.step(1);
    chk(windowOpen_q, 1'b1, "short idle merge");
    m.step(1);
    chk(windowOpen_q, 1'b0, "short idle entry end");
    m.setCke(1'b1);
    m.step(8);
    $display("test short done");
  endtask

  initial begin
    rst_n = 1'b0;
    banksIdle = 1'b1;
    mr0Fast = 1'b0;
    wl = 4'h5;
    repeat (6) @(posedge clk);
    #1;
    chk(odtRxEn_q, 1'b0, "odt rx in reset");
    rst_n = 1'b1;
    m.step(2);
    chk(odtRxEn_q, 1'b1, "odt rx after reset");
    testSync();
    testFrozen();
    testFast();
    testRefresh();
    testShort();
    stop_test();
  end
endmodule

`default_nettype wire
